// ---- pkg/host_uart_defines.vh ----
`ifndef HOST_UART_DEFINES_VH
`define HOST_UART_DEFINES_VH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define RATE_REG_INDEX    8'h3b
`define DATA_REG_INDEX    8'h40
`define STATUS_REG_INDEX  8'h41

// ****************************************************************
// Rate register fields and reset value
// ****************************************************************
`define RATE_RESET        8'h7a
`define EXP_MSB           7
`define EXP_LSB           5
`define MANT_MSB          4
`define MANT_LSB          0
`define SMALL_OFFSET      13'h0001
`define LARGE_OFFSET      13'h0021

// ****************************************************************
// Status register bit positions
// ****************************************************************
`define ST_RX_VALID       0
`define ST_OVERRUN        1
`define ST_FRAME_ERR      2
`define ST_TX_BUSY        3
`define ST_FIFO_FULL      4
`define ST_FIFO_PENDING   5

// ****************************************************************
// Timing: reference and system clock in kHz
// ****************************************************************
`define REF_FREQ_KHZ      17'h069f0
`define CLK_FREQ_KHZ      17'h186a0
`define DATA_BITS         8
`define FIFO_DEPTH        32

`endif

// ---- design/uart_fifo.v ----
`timescale 1ns/1ns

module uart_fifo #(
    parameter WIDTH  = 8,
    parameter DEPTH  = 32,
    parameter ADDR_W = 5
) (
    input  wire             clk,
    input  wire             resetn,
    input  wire             inValid,
    output wire             inReady,
    input  wire [WIDTH-1:0] inData,
    output wire             outValid,
    input  wire             outReady,
    output wire [WIDTH-1:0] outData
);

    // ****************************************************************
    // Storage and pointers
    // ****************************************************************
    reg  [WIDTH-1:0]  mem [0:DEPTH-1];
    reg  [ADDR_W-1:0] wrPtr_q;
    reg  [ADDR_W-1:0] rdPtr_q;
    reg  [ADDR_W:0]   count_q;
    reg               outValid_q;
    reg  [WIDTH-1:0]  outData_q;
    wire              push;
    wire              pull;

    // Output stage adds one word of capacity beyond DEPTH
    assign inReady  = (count_q != DEPTH[ADDR_W:0]);
    assign push     = inValid && inReady;
    assign pull     = (count_q != {(ADDR_W+1){1'b0}}) && (!outValid_q || outReady);
    assign outValid = outValid_q;
    assign outData  = outData_q;

    always @(posedge clk) begin
        if (push) begin
            mem[wrPtr_q] <= inData;
        end
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wrPtr_q    <= {ADDR_W{1'b0}};
            rdPtr_q    <= {ADDR_W{1'b0}};
            count_q    <= {(ADDR_W+1){1'b0}};
            outValid_q <= 1'b0;
            outData_q  <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                wrPtr_q <= (wrPtr_q == DEPTH[ADDR_W-1:0] - 1'b1) ? {ADDR_W{1'b0}}
                                                                  : wrPtr_q + 1'b1;
            end
            if (pull) begin
                outData_q <= mem[rdPtr_q];
                rdPtr_q   <= (rdPtr_q == DEPTH[ADDR_W-1:0] - 1'b1) ? {ADDR_W{1'b0}}
                                                                  : rdPtr_q + 1'b1;
            end
            if (push && !pull) begin
                count_q <= count_q + 1'b1;
            end else if (pull && !push) begin
                count_q <= count_q - 1'b1;
            end
            if (pull) begin
                outValid_q <= 1'b1;
            end else if (outReady) begin
                outValid_q <= 1'b0;
            end
        end
    end

endmodule

// ---- design/host_uart_baud_generator.v ----
// Notes on behaviour
// - Exponent zero: bit rate is reference divided by mantissa plus one.
// - Exponent nonzero: reference over mantissa plus 33, over two^(exponent-1).
// - Character is one start, eight data, one stop bit, no parity.
// - Rate register resets to 7Ah, 115.2 kbit/s.
// - Written exponent and mantissa fields set the serial bit rate.
`timescale 1ns/1ns
`include "host_uart_defines.vh"

module host_uart_baud_generator #(
    parameter ADDR_W     = 12,
    parameter FIFO_DEPTH = `FIFO_DEPTH,
    parameter FIFO_AW    = 5
) (
    input  wire              clk,
    input  wire              resetn,
    input  wire [ADDR_W-1:0] paddr,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [31:0]       pwdata,
    output wire [31:0]       prdata,
    output wire              pready,
    output wire              pslverr,
    input  wire              serialRx,
    output wire              serialTx
);

    // ****************************************************************
    // States
    // ****************************************************************
    localparam ST_IDLE  = 2'b00;
    localparam ST_START = 2'b01;
    localparam ST_DATA  = 2'b10;
    localparam ST_STOP  = 2'b11;

    // ****************************************************************
    // Functions
    // ****************************************************************
    function regHit;
        input [ADDR_W-1:0] a;
        input [7:0]        idx;
        begin
            regHit = (a[1:0] == 2'b00) &&
                     (a[ADDR_W-1:2] == {{(ADDR_W-10){1'b0}}, idx});
        end
    endfunction

    // Reference ticks per bit; largest setting is 4096
    function [12:0] bitDivisor;
        input [7:0] rate;
        reg   [2:0]  e;
        reg   [12:0] m;
        begin
            e = rate[`EXP_MSB:`EXP_LSB];
            m = {8'h00, rate[`MANT_MSB:`MANT_LSB]};
            if (e == 3'h0) begin
                bitDivisor = m + `SMALL_OFFSET;
            end else begin
                bitDivisor = (m + `LARGE_OFFSET) << (e - 3'h1);
            end
        end
    endfunction

    // ****************************************************************
    // Declarations
    // ****************************************************************
    reg  [7:0]  rate_q;
    reg  [16:0] phase_q;
    reg         refTick_q;
    reg  [31:0] prdata_q;
    reg         pslverr_q;
    reg         readPopArm_q;
    reg  [1:0]  txState_q;
    reg  [7:0]  txShift_q;
    reg  [2:0]  txBit_q;
    reg  [12:0] txCnt_q;
    reg  [12:0] txDiv_q;
    reg         serialTx_q;
    reg  [1:0]  rxState_q;
    reg  [7:0]  rxShift_q;
    reg  [2:0]  rxBit_q;
    reg  [12:0] rxCnt_q;
    reg  [12:0] rxDiv_q;
    reg  [7:0]  rxData_q;
    reg         rxValid_q;
    reg         overrun_q;
    reg         frameErr_q;
    reg  [31:0] readMux;
    wire [17:0] phaseSum;
    wire        setup;
    wire        access;
    wire        done;
    wire        hitRate;
    wire        hitData;
    wire        hitStatus;
    wire        fifoInValid;
    wire        fifoInReady;
    wire        fifoOutValid;
    wire        fifoOutReady;
    wire [7:0]  fifoOutData;
    wire        txEnd;
    wire [12:0] rxTarget;
    wire        rxEnd;
    wire        rxDone;
    wire        rxPop;

    // ****************************************************************
    // Reference tick from system clock
    // ****************************************************************
    // Fractional accumulator: jitter of one system cycle per tick, traded
    // for running everything on one clock
    assign phaseSum = {1'b0, phase_q} + {1'b0, `REF_FREQ_KHZ};

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phase_q   <= 17'h00000;
            refTick_q <= 1'b0;
        end else if (phaseSum >= {1'b0, `CLK_FREQ_KHZ}) begin
            phase_q   <= phaseSum[16:0] - `CLK_FREQ_KHZ;
            refTick_q <= 1'b1;
        end else begin
            phase_q   <= phaseSum[16:0];
            refTick_q <= 1'b0;
        end
    end

    // ****************************************************************
    // APB slave
    // ****************************************************************
    assign setup     = psel && !penable;
    assign access    = psel && penable;
    assign hitRate   = regHit(paddr, `RATE_REG_INDEX);
    assign hitData   = regHit(paddr, `DATA_REG_INDEX);
    assign hitStatus = regHit(paddr, `STATUS_REG_INDEX);

    // Writes to a full transmit queue stall the bus
    assign fifoInValid = access && pwrite && hitData;
    assign pready      = !(fifoInValid && !fifoInReady);
    assign done        = access && pready;
    assign prdata      = prdata_q;
    assign pslverr     = pslverr_q;

    // Pop only data that was already valid when sampled in setup
    assign rxPop = done && !pwrite && hitData && readPopArm_q;

    always @* begin
        readMux = 32'h00000000;
        if (hitRate) begin
            readMux[7:0] = rate_q;
        end else if (hitData) begin
            readMux[7:0] = rxData_q;
        end else if (hitStatus) begin
            readMux[`ST_RX_VALID]     = rxValid_q;
            readMux[`ST_OVERRUN]      = overrun_q;
            readMux[`ST_FRAME_ERR]    = frameErr_q;
            readMux[`ST_TX_BUSY]      = (txState_q != ST_IDLE);
            readMux[`ST_FIFO_FULL]    = !fifoInReady;
            readMux[`ST_FIFO_PENDING] = fifoOutValid;
        end
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prdata_q     <= 32'h00000000;
            pslverr_q    <= 1'b0;
            readPopArm_q <= 1'b0;
            rate_q       <= `RATE_RESET;
        end else begin
            if (setup) begin
                prdata_q     <= pwrite ? 32'h00000000 : readMux;
                pslverr_q    <= !(hitRate || hitData || hitStatus);
                readPopArm_q <= rxValid_q;
            end
            if (done && pwrite && hitRate) begin
                rate_q <= pwdata[7:0];
            end
        end
    end

    // ****************************************************************
    // Transmit queue
    // ****************************************************************
    uart_fifo #(
        .WIDTH  (8),
        .DEPTH  (FIFO_DEPTH),
        .ADDR_W (FIFO_AW)
    ) txFifo (
        .clk      (clk),
        .resetn   (resetn),
        .inValid  (fifoInValid),
        .inReady  (fifoInReady),
        .inData   (pwdata[7:0]),
        .outValid (fifoOutValid),
        .outReady (fifoOutReady),
        .outData  (fifoOutData)
    );

    // ****************************************************************
    // Transmitter
    // ****************************************************************
    // Start only on a reference tick so the start bit is a full bit long
    assign fifoOutReady = (txState_q == ST_IDLE) && refTick_q;
    assign txEnd        = refTick_q && (txCnt_q == txDiv_q - 13'h0001);
    assign serialTx     = serialTx_q;

    // Rate is latched per character so a rewrite never tears a frame
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            txState_q  <= ST_IDLE;
            txShift_q  <= 8'h00;
            txBit_q    <= 3'h0;
            txCnt_q    <= 13'h0000;
            txDiv_q    <= 13'h0001;
            serialTx_q <= 1'b1;
        end else begin
            if (txState_q != ST_IDLE && refTick_q) begin
                txCnt_q <= txEnd ? 13'h0000 : txCnt_q + 13'h0001;
            end
            case (txState_q)
                ST_IDLE: begin
                    serialTx_q <= 1'b1;
                    if (fifoOutValid && refTick_q) begin
                        txShift_q  <= fifoOutData;
                        txDiv_q    <= bitDivisor(rate_q);
                        txCnt_q    <= 13'h0000;
                        serialTx_q <= 1'b0;
                        txState_q  <= ST_START;
                    end
                end
                ST_START: begin
                    if (txEnd) begin
                        serialTx_q <= txShift_q[0];
                        txShift_q  <= {1'b0, txShift_q[7:1]};
                        txBit_q    <= 3'h0;
                        txState_q  <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (txEnd) begin
                        if (txBit_q == 3'h7) begin
                            serialTx_q <= 1'b1;
                            txState_q  <= ST_STOP;
                        end else begin
                            serialTx_q <= txShift_q[0];
                            txShift_q  <= {1'b0, txShift_q[7:1]};
                            txBit_q    <= txBit_q + 3'h1;
                        end
                    end
                end
                default: begin
                    if (txEnd) begin
                        txState_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // Receiver
    // ****************************************************************
    assign rxTarget = (rxState_q == ST_START) ? {1'b0, rxDiv_q[12:1]} : rxDiv_q;
    assign rxEnd    = refTick_q && (rxCnt_q + 13'h0001 >= rxTarget);
    assign rxDone   = (rxState_q == ST_STOP) && rxEnd && serialRx;

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rxState_q <= ST_IDLE;
            rxShift_q <= 8'h00;
            rxBit_q   <= 3'h0;
            rxCnt_q   <= 13'h0000;
            rxDiv_q   <= 13'h0001;
            rxData_q  <= 8'h00;
        end else begin
            if (rxState_q != ST_IDLE && refTick_q) begin
                rxCnt_q <= rxEnd ? 13'h0000 : rxCnt_q + 13'h0001;
            end
            case (rxState_q)
                ST_IDLE: begin
                    if (!serialRx) begin
                        rxDiv_q   <= bitDivisor(rate_q);
                        rxCnt_q   <= 13'h0000;
                        rxState_q <= ST_START;
                    end
                end
                ST_START: begin
                    // Half a bit in: a glitch shorter than that is dropped
                    if (rxEnd) begin
                        rxBit_q   <= 3'h0;
                        rxState_q <= serialRx ? ST_IDLE : ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (rxEnd) begin
                        rxShift_q <= {serialRx, rxShift_q[7:1]};
                        rxBit_q   <= rxBit_q + 3'h1;
                        if (rxBit_q == 3'h7) begin
                            rxState_q <= ST_STOP;
                        end
                    end
                end
                default: begin
                    if (rxEnd) begin
                        if (serialRx) begin
                            rxData_q <= rxShift_q;
                        end
                        rxState_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // Receive flags: a new event beats a clear in the same cycle
    // ****************************************************************
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rxValid_q  <= 1'b0;
            overrun_q  <= 1'b0;
            frameErr_q <= 1'b0;
        end else begin
            if (rxDone) begin
                rxValid_q <= 1'b1;
            end else if (rxPop) begin
                rxValid_q <= 1'b0;
            end
            if (rxDone && rxValid_q && !rxPop) begin
                overrun_q <= 1'b1;
            end else if (done && pwrite && hitStatus && pwdata[`ST_OVERRUN]) begin
                overrun_q <= 1'b0;
            end
            if ((rxState_q == ST_STOP) && rxEnd && !serialRx) begin
                frameErr_q <= 1'b1;
            end else if (done && pwrite && hitStatus && pwdata[`ST_FRAME_ERR]) begin
                frameErr_q <= 1'b0;
            end
        end
    end

endmodule

// ---- test/host_uart_checker.sv ----
`timescale 1ns/1ns
// ****
// Port checker
// ****
module host_uart_checker #(
    parameter ADDR_W = 12
) (
    input wire logic              clk,
    input wire logic              resetn,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              serialRx,
    input wire logic              serialTx
);
    logic [7:0] rateQ;
    logic       acc;
    logic       mapped;
    assign acc = psel && penable;
    assign mapped = paddr == 12'h0ec || paddr == 12'h100 || paddr == 12'h104;
    // Shadow rate, moves only on a completed write
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rateQ <= 8'h7a;
        end else if (acc && pready && pwrite && paddr == 12'h0ec) begin
            rateQ <= pwdata[7:0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    chk_reset_idle: assert property ($rose(resetn) |-> serialTx && !pslverr)
        else $error("line not idle after reset");
    chk_rate_readback: assert property (acc && !pwrite && paddr == 12'h0ec |-> prdata == {24'h0, rateQ})
        else $error("rate register read wrong");
    chk_unmapped_err: assert property (acc && !mapped |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    chk_mapped_ok: assert property (acc && mapped |-> !pslverr)
        else $error("mapped access refused");
    chk_read_nowait: assert property (acc && !pwrite |-> pready)
        else $error("read delayed");
    chk_ready_idle: assert property (!(psel && pwrite && paddr == 12'h100) |-> pready)
        else $error("ready low without data write");
    chk_stall_hold: assert property (acc && !pready |=> $stable(prdata) && $stable(pslverr))
        else $error("response moved during stall");
    chk_data_width: assert property (acc && !pwrite && paddr == 12'h100 |-> prdata[31:8] == 24'h0)
        else $error("data read beyond eight bits");
    chk_status_width: assert property (acc && !pwrite && paddr == 12'h104 |-> prdata[31:6] == 26'h0)
        else $error("status reserved bits set");
    chk_start_min: assert property ($fell(serialTx) |=> !serialTx [*2])
        else $error("start bit too short");
    cover property (acc && pready && pwrite && paddr == 12'h0ec);
    cover property (acc && !pready);
    cover property ($fell(serialTx));
    cover property (acc && !mapped);
endmodule
bind host_uart_baud_generator host_uart_checker #(.ADDR_W(ADDR_W)) i_host_uart_checker (
    .clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serialRx(serialRx), .serialTx(serialTx)
);

// ---- test/host_serial_partner.sv ----
`timescale 1ns/1ns
// ****
// Far-side host serial port
// ****
module host_serial_partner (
    input  wire logic        clk,
    input  wire logic        serialTx,
    output logic             serialRx,
    input  wire logic [15:0] divisor
);
    logic [8:0] gotQ[$];
    real        widthQ[$];
    logic [8:0] frame;
    real        bitNs;
    real        t0;
    real        tRise;
    always_comb bitNs = divisor * 1000.0 / 27.12;
    initial serialRx = 1'h1;
    always @(posedge serialTx) tRise = $realtime;
    // Centre sampling; last rise gives nine bits when bit 7 is zero
    always begin
        @(negedge serialTx);
        t0 = $realtime;
        #(bitNs / 2.0);
        for (int k = 0; k < 9; k++) begin
            #(bitNs);
            frame[k] = serialTx;
        end
        gotQ.push_back(frame);
        widthQ.push_back(tRise - t0);
    end
    // Bit edges land on falling clock edges, away from the sampling edge
    task automatic sendByte(input logic [7:0] b, input logic stopBit);
        logic [9:0] f;
        real        tEnd;
        f = {stopBit, b, 1'h0};
        tEnd = $realtime;
        for (int k = 0; k < 10; k++) begin
            @(negedge clk);
            serialRx = f[k];
            tEnd = tEnd + bitNs;
            #(tEnd - $realtime);
        end
        @(negedge clk);
        serialRx = 1'h1;
    endtask
endmodule

// ---- test/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
    logic        clk, resetn, psel, penable, pwrite, pready, pslverr, serialRx, serialTx, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, seed, rd;
    logic [15:0] divisor;
    logic [7:0]  r;
    logic [7:0]  sent[$];
    integer      bad_count, n_compared, stalls, i;
    localparam logic [7:0] RATES[5] = '{8'h15, 8'h1c, 8'h3a, 8'h5a, 8'h74};

    host_uart_baud_generator i_host_uart_baud_generator (
        .clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serialRx(serialRx), .serialTx(serialTx)
    );
    host_serial_partner i_host_serial_partner (
        .clk(clk), .serialTx(serialTx), .serialRx(serialRx), .divisor(divisor)
    );
    always #5 clk = ~clk;

    // ****
    // Helpers
    // ****
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function automatic logic [15:0] rateDiv(input logic [7:0] v);
        if (v[7:5] == 3'h0) return {11'h0, v[4:0]} + 16'h0001;
        return ({11'h0, v[4:0]} + 16'h0021) << (v[7:5] - 3'h1);
    endfunction
    task automatic tally_and_finish;
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input logic ok, input string m);
        n_compared++;
        if (ok !== 1'h1) begin
            bad_count++;
            $display("MISMATCH at %0t: %s", $time, m);
        end
    endtask
    // Entered just after a clock edge (falling after sendByte); one idle cycle follows each transfer
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        integer n;
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 20000);
        if (pready !== 1'h1) begin
            check(1'h0, "bus wait");
            tally_and_finish();
        end
        if (n > 1) stalls++;
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask
    task automatic setRate(input logic [7:0] v);
        apb(1'h1, 12'h0ec, {24'h0, v});
        apb(1'h0, 12'h0ec, 32'h0);
        check(rd === {24'h0, v}, "rate readback");
        divisor = rateDiv(v);
    endtask
    task automatic sendTx(input logic [7:0] b);
        apb(1'h1, 12'h100, {24'h0, b});
        sent.push_back(b);
    endtask
    // Width is nine bit times from start edge when bit 7 is zero
    task automatic drain;
        integer n;
        logic [8:0] got;
        real w, ew;
        while (sent.size() > 0) begin
            n = 0;
            while (i_host_serial_partner.gotQ.size() == 0 && n < 40000) begin
                @(posedge clk);
                n++;
            end
            if (n >= 40000) begin
                check(1'h0, "no character");
                tally_and_finish();
            end
            got = i_host_serial_partner.gotQ.pop_front();
            w = i_host_serial_partner.widthQ.pop_front();
            ew = 9.0 * divisor * 1000.0 / 27.12;
            check(got === {1'h1, sent[0]}, "tx character");
            if (sent[0][7] == 1'h0) check(w > ew - 25.0 && w < ew + 25.0, "bit rate");
            void'(sent.pop_front());
        end
    endtask
    task automatic pollStatus;
        integer n;
        n = 0;
        rd = 32'h0;
        while (rd[2:0] == 3'h0 && n < 50) begin
            apb(1'h0, 12'h104, 32'h0);
            n++;
        end
        if (rd[2:0] == 3'h0) begin
            check(1'h0, "status poll");
            tally_and_finish();
        end
    endtask

    // ****
    // Main sequence
    // ****
    initial begin
        clk = 1'h0;
        resetn = 1'h0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        seed = 32'h875d;
        bad_count = 0;
        n_compared = 0;
        stalls = 0;
        divisor = rateDiv(8'h7a);
        repeat (12) @(posedge clk);
        resetn <= 1'h1;
        @(posedge clk);
        check(serialTx === 1'h1, "idle level");
        apb(1'h0, 12'h0ec, 32'h0);
        check(rd === 32'h7a && err === 1'h0, "rate reset value");
        apb(1'h1, 12'h0f0, 32'h15);
        check(err === 1'h1, "unmapped write");
        apb(1'h0, 12'h0ec, 32'h0);
        check(rd === 32'h7a, "unmapped write changed rate");
        sendTx(8'h4b);
        drain();
        for (i = 0; i < 5; i++) begin
            setRate(RATES[i]);
            sendTx(8'h35 ^ i[7:0]);
            drain();
        end
        for (i = 0; i < 4; i++) begin
            seed = xorshift(seed);
            r = seed[5] ? {3'h1, seed[4:0]} : {5'h03, seed[2:0]};
            setRate(r);
            sendTx({1'h0, seed[14:8]});
            sendTx(seed[23:16]);
            drain();
        end
        // Fastest legal rate keeps the full-queue run short
        setRate(8'h15);
        stalls = 0;
        for (i = 0; i < 36; i++) begin
            seed = xorshift(seed);
            sendTx(seed[7:0]);
        end
        check(stalls > 0, "queue never refused");
        apb(1'h0, 12'h104, 32'h0);
        check((rd[3] | rd[5]) === 1'h1 && rd[31:6] === 26'h0, "tx status");
        drain();
        i_host_serial_partner.sendByte(8'hc6, 1'h1);
        pollStatus();
        check(rd[2:0] === 3'h1, "rx valid");
        apb(1'h0, 12'h100, 32'h0);
        check(rd === 32'hc6, "rx byte");
        i_host_serial_partner.sendByte(8'h01, 1'h1);
        i_host_serial_partner.sendByte(8'h80, 1'h1);
        pollStatus();
        check(rd[2:0] === 3'h3, "overrun");
        apb(1'h0, 12'h100, 32'h0);
        check(rd === 32'h80, "newest byte kept");
        apb(1'h1, 12'h104, 32'h2);
        i_host_serial_partner.sendByte(8'h5a, 1'h0);
        pollStatus();
        check(rd[2:0] === 3'h4, "frame error");
        tally_and_finish();
    end
endmodule
